// [hw/dsb_pkg.sv]
// Shared constants and carrier types for the boost and software command decoder
package dsb_pkg;

    // Serial frame layout
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam int RW_BIT = 23;
    localparam int ADDR_HI_BIT = 22;
    localparam int ADDR_LO_BIT = 21;
    localparam int RSEL_HI = 20;
    localparam int RSEL_LO = 16;
    localparam int SEL_HI = 15;
    localparam int SEL_LO = 13;
    localparam int TOGGLE_BIT = 12;
    localparam int CODE_HI = 11;
    localparam int CODE_LO = 0;
    localparam int SLEW_CH_HI = 17;
    localparam int SLEW_CH_LO = 16;

    // Write selectors in bits 15..13
    localparam logic [2:0] SEL_SOFTWARE = 3'h4;
    localparam logic [2:0] SEL_BOOST = 3'h3;
    localparam logic [2:0] SEL_SLEW = 3'h0;

    // Software command codes
    localparam logic [11:0] CODE_RESET = 12'h555;
    localparam logic [11:0] CODE_KEEPALIVE = 12'h195;

    // Read select codes
    localparam logic [4:0] RD_SLEW_BASE = 5'h14;
    localparam logic [4:0] RD_STATUS = 5'h18;
    localparam logic [4:0] RD_BOOST = 5'h1A;

    // Status register layout
    localparam int STATUS_TOGGLE_POS = 11;

    // Boost field codes
    localparam logic [1:0] PHASE_SAME_EDGE = 2'h0;
    localparam logic [1:0] PHASE_AB_CD = 2'h1;
    localparam logic [1:0] PHASE_AC_BD = 2'h2;
    localparam logic [1:0] PHASE_QUAD = 2'h3;
    localparam logic [1:0] FREQ_250K = 2'h0;
    localparam logic [1:0] FREQ_410K = 2'h1;
    localparam logic [1:0] FREQ_650K = 2'h2;
    localparam logic [1:0] MAXV_23V0 = 2'h0;
    localparam logic [1:0] MAXV_29V5 = 2'h3;

    typedef struct packed {
        logic       comp_bypass;   // bit 6
        logic [1:0] phase;         // bits 5..4
        logic [1:0] freq;          // bits 3..2
        logic [1:0] max_voltage;   // bits 1..0
    } dsb_boost_cfg_t;

    typedef struct packed {
        logic       enable;        // bit 12
        logic [3:0] clock;         // bits 6..3
        logic [2:0] step;          // bits 2..0
    } dsb_slew_cfg_t;

    localparam dsb_boost_cfg_t BOOST_RESET = '{
        comp_bypass: 1'b0, phase: PHASE_SAME_EDGE, freq: FREQ_410K, max_voltage: MAXV_23V0};
    localparam dsb_slew_cfg_t SLEW_RESET = '{enable: 1'b0, clock: 4'h0, step: 3'h0};

endpackage : dsb_pkg

// [hw/dsb_shift.sv]
// Serial frame shifter: samples the 3-wire link and shifts out readback data
`timescale 1ns/1ps
`default_nettype none
module dsb_shift (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Serial link
    input wire logic sclk_in,
    input wire logic sync_n_in,
    input wire logic sdin_in,
    output logic sdo_out,
    // Frame side
    input wire logic [dsb_pkg::FRAME_BITS-1:0] load_word_in,
    output logic frame_done_out,
    output logic [dsb_pkg::FRAME_BITS-1:0] frame_word_out
);

    logic sclk_q, sclk_d;
    logic sync_q, sync_d;
    logic [dsb_pkg::FRAME_BITS-1:0] in_q, in_d;
    logic [dsb_pkg::FRAME_BITS-1:0] out_q, out_d;
    logic [dsb_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic done_q, done_d;
    logic [dsb_pkg::FRAME_BITS-1:0] word_q, word_d;
    logic fall;

    localparam logic [dsb_pkg::CNT_W-1:0] FULL = dsb_pkg::FRAME_BITS[dsb_pkg::CNT_W-1:0];

    always_comb begin
        fall = sclk_q && !sclk_in && !sync_n_in;
        sclk_d = sclk_in;
        sync_d = sync_n_in;
        in_d = in_q;
        out_d = out_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        word_d = word_q;
        if (sync_q && !sync_n_in) begin
            // Readback word is captured as the frame opens
            cnt_d = '0;
            out_d = load_word_in;
        end else if (fall) begin
            // Host has sampled SDO by the time the edge is seen here
            in_d = {in_q[dsb_pkg::FRAME_BITS-2:0], sdin_in};
            out_d = {out_q[dsb_pkg::FRAME_BITS-2:0], 1'b0};
            if (cnt_q <= FULL) begin
                cnt_d = cnt_q + 1'b1;
            end
        end else if (!sync_q && sync_n_in) begin
            // Frames of the wrong length are dropped
            if (cnt_q == FULL) begin
                done_d = 1'b1;
                word_d = in_q;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            sclk_q <= 1'b0;
            sync_q <= 1'b1;
            in_q <= '0;
            out_q <= '0;
            cnt_q <= '0;
            done_q <= 1'b0;
            word_q <= '0;
        end else begin
            sclk_q <= sclk_d;
            sync_q <= sync_d;
            in_q <= in_d;
            out_q <= out_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            word_q <= word_d;
        end
    end

    assign sdo_out = out_q[dsb_pkg::FRAME_BITS-1];
    assign frame_done_out = done_q;
    assign frame_word_out = word_q;

endmodule : dsb_shift
`default_nettype wire

// [hw/dsb_top.sv]
// Command decoder for software, boost control and slew registers with readback
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module dsb_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Device address strap
    input wire logic [1:0] device_addr_in,
    // Serial link
    input wire logic sclk_in,
    input wire logic sync_n_in,
    input wire logic sdin_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    // Boost converter configuration
    output dsb_pkg::dsb_boost_cfg_t boost_cfg_out,
    // Per-channel slew configuration, index 0 is channel A
    output dsb_pkg::dsb_slew_cfg_t [3:0] slew_cfg_out,
    // Software register effects
    output logic user_toggle_out,
    output logic soft_reset_out,
    output logic keepalive_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame capture
    logic frame_done;
    logic [dsb_pkg::FRAME_BITS-1:0] frame_word;
    logic [dsb_pkg::FRAME_BITS-1:0] load_word;
    logic [15:0] rd_word_q, rd_word_d;

    assign load_word = {8'h00, rd_word_q};

    dsb_shift u_shift (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .sclk_in(sclk_in),
        .sync_n_in(sync_n_in),
        .sdin_in(sdin_in),
        .sdo_out(sdo_out),
        .load_word_in(load_word),
        .frame_done_out(frame_done),
        .frame_word_out(frame_word)
    );

    // Driven only while the frame is open, so several devices can share SDO
    assign sdo_oe_out = !sync_n_in;

    ////////////////////////////////////////////////////////////////////////////
    // Word decode
    logic addr_match, is_read, is_write;
    logic [2:0] sel;
    logic [11:0] code;
    logic [4:0] rsel;
    logic sw_write, boost_write, slew_write, reset_cmd;

    always_comb begin
        addr_match = frame_word[dsb_pkg::ADDR_HI_BIT:dsb_pkg::ADDR_LO_BIT]
                     == device_addr_in;
        is_read = frame_done && addr_match && frame_word[dsb_pkg::RW_BIT];
        is_write = frame_done && addr_match && !frame_word[dsb_pkg::RW_BIT];
        sel = frame_word[dsb_pkg::SEL_HI:dsb_pkg::SEL_LO];
        code = frame_word[dsb_pkg::CODE_HI:dsb_pkg::CODE_LO];
        rsel = frame_word[dsb_pkg::RSEL_HI:dsb_pkg::RSEL_LO];
        sw_write = is_write && (sel == dsb_pkg::SEL_SOFTWARE);
        boost_write = is_write && (sel == dsb_pkg::SEL_BOOST);
        slew_write = is_write && (sel == dsb_pkg::SEL_SLEW);
        reset_cmd = sw_write && (code == dsb_pkg::CODE_RESET);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration state
    dsb_pkg::dsb_boost_cfg_t boost_q, boost_d;
    dsb_pkg::dsb_slew_cfg_t [3:0] slew_q, slew_d;
    logic toggle_q, toggle_d;
    logic soft_reset_q, soft_reset_d;
    logic keepalive_q, keepalive_d;
    logic [15:0] status_word;

    always_comb begin
        boost_d = boost_q;
        slew_d = slew_q;
        toggle_d = toggle_q;
        soft_reset_d = reset_cmd;
        keepalive_d = sw_write && (code == dsb_pkg::CODE_KEEPALIVE);
        if (reset_cmd) begin
            // Complete reset wins over the toggle carried in the same word
            boost_d = dsb_pkg::BOOST_RESET;
            slew_d = {4{dsb_pkg::SLEW_RESET}};
            toggle_d = 1'b0;
        end else if (sw_write) begin
            toggle_d = frame_word[dsb_pkg::TOGGLE_BIT];
        end else if (boost_write) begin
            // Bits 12..7 are don't care
            boost_d = frame_word[6:0];
        end else if (slew_write) begin
            slew_d[frame_word[dsb_pkg::SLEW_CH_HI:dsb_pkg::SLEW_CH_LO]] =
                {frame_word[dsb_pkg::TOGGLE_BIT], frame_word[6:0]};
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            boost_q <= dsb_pkg::BOOST_RESET;
            slew_q <= {4{dsb_pkg::SLEW_RESET}};
            toggle_q <= 1'b0;
            soft_reset_q <= 1'b0;
            keepalive_q <= 1'b0;
        end else begin
            boost_q <= boost_d;
            slew_q <= slew_d;
            toggle_q <= toggle_d;
            soft_reset_q <= soft_reset_d;
            keepalive_q <= keepalive_d;
        end
    end

    assign boost_cfg_out = boost_q;
    assign slew_cfg_out = slew_q;
    assign user_toggle_out = toggle_q;
    assign soft_reset_out = soft_reset_q;
    assign keepalive_out = keepalive_q;

    ////////////////////////////////////////////////////////////////////////////
    // Readback selection
    function automatic logic [15:0] slew_word(input dsb_pkg::dsb_slew_cfg_t s);
        slew_word = {3'h0, s.enable, 5'h00, s.clock, s.step};
    endfunction : slew_word

    always_comb begin
        status_word = 16'h0000;
        status_word[dsb_pkg::STATUS_TOGGLE_POS] = toggle_q;
        rd_word_d = rd_word_q;
        if (is_read) begin
            // Registers outside this block read back as zero
            unique case (rsel)
                dsb_pkg::RD_STATUS: rd_word_d = status_word;
                dsb_pkg::RD_BOOST: rd_word_d = {9'h000, boost_q};
                dsb_pkg::RD_SLEW_BASE: rd_word_d = slew_word(slew_q[0]);
                dsb_pkg::RD_SLEW_BASE + 5'h01: rd_word_d = slew_word(slew_q[1]);
                dsb_pkg::RD_SLEW_BASE + 5'h02: rd_word_d = slew_word(slew_q[2]);
                dsb_pkg::RD_SLEW_BASE + 5'h03: rd_word_d = slew_word(slew_q[3]);
                default: rd_word_d = 16'h0000;
            endcase
        end else if (frame_done) begin
            // Any other complete frame ends the pending readback
            rd_word_d = 16'h0000;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rd_word_q <= 16'h0000;
        end else begin
            rd_word_q <= rd_word_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_toggle_copy: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        sw_write && !reset_cmd |=> user_toggle_out == $past(frame_word[12]))
        else $error("toggle bit not copied");

    a_reset_code: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        reset_cmd |=> soft_reset_out && boost_cfg_out == dsb_pkg::BOOST_RESET && !user_toggle_out)
        else $error("software reset not applied");

    a_keepalive_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        keepalive_out |-> $past(sw_write) && $past(code) == dsb_pkg::CODE_KEEPALIVE)
        else $error("keep-alive pulse without code");

    a_boost_fields: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        boost_write |=> boost_cfg_out == $past(frame_word[6:0]))
        else $error("boost fields not taken from bits 6..0");

    a_boost_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        frame_done && !addr_match |=> $stable(boost_cfg_out) && $stable(user_toggle_out))
        else $error("foreign address changed state");

    a_read_no_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        is_read |=> $stable(boost_cfg_out) && $stable(slew_cfg_out))
        else $error("read request altered registers");

    a_read_boost: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        is_read && rsel == dsb_pkg::RD_BOOST |=> rd_word_q == {9'h000, $past(boost_q)})
        else $error("boost readback wrong");

    a_read_status: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        is_read && rsel == dsb_pkg::RD_STATUS |=> rd_word_q[11] == $past(toggle_q))
        else $error("status readback wrong");

    a_read_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        frame_done && !is_read |=> rd_word_q == 16'h0000)
        else $error("pending readback not cleared");

    a_slew_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !slew_write && !reset_cmd |=> $stable(slew_cfg_out))
        else $error("slew settings changed without a write");

    a_toggle_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !sw_write |=> $stable(user_toggle_out))
        else $error("toggle changed without a software write");

    a_reset_default: assert property (@(posedge clk_in)
        !reset_n_in |=> boost_cfg_out.freq == dsb_pkg::FREQ_410K && !boost_cfg_out.comp_bypass)
        else $error("boost defaults not restored");

endmodule : dsb_top
`default_nettype wire

// [verif/dsb_host.sv]
// Host serial master model driving the 3-wire link
`timescale 1ns/1ps
`default_nettype none
module dsb_host (
    // Clock
    input wire logic clk_in,
    // Serial link
    input wire logic sdo_in,
    output logic sclk_out,
    output logic sync_n_out,
    output logic sdin_out
);
    initial begin
        sclk_out = 1'b0;
        sync_n_out = 1'b1;
        sdin_out = 1'b0;
    end

    // One frame, MSB first; sdo is taken just before each falling edge
    task automatic xfer(input logic [23:0] word_in, input int nbits, output logic [23:0] rx_out);
        int i;
        rx_out = 24'h000000;
        @(posedge clk_in) sync_n_out <= 1'b0;
        repeat (2) @(posedge clk_in);
        for (i = 0; i < nbits; i++) begin
            // Low phase of two cycles, matching the high phase
            repeat (2) @(posedge clk_in);
            sdin_out <= word_in[23-i];
            sclk_out <= 1'b1;
            repeat (2) @(posedge clk_in);
            rx_out = {rx_out[22:0], sdo_in};
            sclk_out <= 1'b0;
        end
        repeat (2) @(posedge clk_in);
        sync_n_out <= 1'b1;
        // Released data line shows the inverse, not a stale value
        sdin_out <= ~sdin_out;
        repeat (5) @(posedge clk_in);
    endtask : xfer
endmodule : dsb_host
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_in = 1'b0;
    logic reset_n_in;
    logic [1:0] dev_a;
    logic sclk, sync_n, sdin, sdo, sdo_oe, toggle, sreset, kalive;
    dsb_pkg::dsb_boost_cfg_t boost;
    dsb_pkg::dsb_slew_cfg_t [3:0] slew;
    logic [31:0] seed = 32'hE0F52EBB;
    int num_errors = 0;
    int n_checks = 0;
    int ka_cnt = 0;
    int sr_cnt = 0;
    int cyc = 0;

    always #4 clk_in = ~clk_in;

    dsb_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .device_addr_in(dev_a),
        .sclk_in(sclk), .sync_n_in(sync_n), .sdin_in(sdin), .sdo_out(sdo),
        .sdo_oe_out(sdo_oe), .boost_cfg_out(boost), .slew_cfg_out(slew),
        .user_toggle_out(toggle), .soft_reset_out(sreset), .keepalive_out(kalive));
    dsb_host host (.clk_in(clk_in), .sdo_in(sdo), .sclk_out(sclk), .sync_n_out(sync_n),
        .sdin_out(sdin));

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand

    function automatic logic [23:0] rd_w(input logic [1:0] a, input logic [4:0] s,
        input logic [15:0] j);
        return {1'b1, a, s, j};
    endfunction : rd_w

    function automatic logic [23:0] nop_w(input logic [1:0] a);
        return {1'b0, a, 5'h1C, 16'hE000};
    endfunction : nop_w

    function automatic logic [23:0] sw_w(input logic [1:0] a, input logic t, input logic [11:0] c);
        return {1'b0, a, 5'h00, dsb_pkg::SEL_SOFTWARE, t, c};
    endfunction : sw_w

    ////////////////////////////////////////////////////////////////////////////
    // Pulse counters; cycle limit cuts a hang short
    always @(posedge clk_in) begin
        cyc++;
        if (kalive === 1'b1) ka_cnt++;
        if (sreset === 1'b1) sr_cnt++;
        // Logical not keeps the expectation one bit wide
        if (reset_n_in === 1'b1) check(sdo_oe, !sync_n);
        if (cyc > 60000) begin
            num_errors++;
            finish_test();
        end
    end

    initial begin
        logic [31:0] r;
        logic [23:0] rx;
        logic [6:0] cfg;
        int i, c0;
        reset_n_in = 1'b0;
        dev_a = 2'h0;
        r = next_rand();
        @(posedge clk_in) dev_a <= r[1:0];
        repeat (19) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        check(boost, dsb_pkg::BOOST_RESET);
        check(toggle, 1'b0);
        // Boost writes: every field code, random don't-care bits, then readback
        for (i = 0; i < 8; i++) begin
            r = next_rand();
            cfg = (i < 4) ? {i[0], i[1:0], i[1:0], i[1:0]} : r[6:0];
            host.xfer({1'b0, dev_a, r[20:16], dsb_pkg::SEL_BOOST, r[12:7], cfg}, 24, rx);
            check(boost, cfg);
            host.xfer(rd_w(dev_a, dsb_pkg::RD_BOOST, r[31:16]), 24, rx);
            check(boost, cfg);
            host.xfer(i[0] ? nop_w(dev_a) : rd_w(dev_a, dsb_pkg::RD_STATUS, 16'h0),
                24, rx);
            check(rx, {17'h0, cfg});
            host.xfer(nop_w(dev_a), 24, rx);
        end
        // Foreign address and short frame are both ignored
        host.xfer({1'b0, dev_a ^ 2'h1, 5'h0, dsb_pkg::SEL_BOOST, 6'h0, ~cfg}, 24, rx);
        check(boost, cfg);
        host.xfer({1'b0, dev_a, 5'h0, dsb_pkg::SEL_BOOST, 6'h0, ~cfg}, 23, rx);
        check(boost, cfg);
        // Read aimed at another device leaves nothing to shift out
        host.xfer(rd_w(dev_a ^ 2'h2, dsb_pkg::RD_BOOST, 16'h0), 24, rx);
        host.xfer(nop_w(dev_a), 24, rx);
        check(rx, 24'h000000);
        // Per-channel slew settings and their readback
        for (i = 0; i < 4; i++) begin
            r = next_rand();
            host.xfer({1'b0, dev_a, 3'h0, i[1:0], dsb_pkg::SEL_SLEW, r[12], 5'h0, r[6:0]}, 24, rx);
            check(slew[i], {r[12], r[6:0]});
            host.xfer(rd_w(dev_a, dsb_pkg::RD_SLEW_BASE + i[4:0], 16'h0), 24, rx);
            host.xfer(nop_w(dev_a), 24, rx);
            check(rx, {11'h0, r[12], 5'h0, r[6:0]});
        end
        // User toggle set then cleared, seen in status bit 11
        for (i = 1; i >= 0; i--) begin
            host.xfer(sw_w(dev_a, i[0], 12'h000), 24, rx);
            check(toggle, i[0]);
            host.xfer(rd_w(dev_a, dsb_pkg::RD_STATUS, 16'h0), 24, rx);
            host.xfer(nop_w(dev_a), 24, rx);
            check(rx[11], i[0]);
        end
        c0 = ka_cnt;
        host.xfer(sw_w(dev_a, 1'b0, dsb_pkg::CODE_KEEPALIVE), 24, rx);
        check(ka_cnt - c0, 1);
        host.xfer(sw_w(dev_a, 1'b1, 12'h000), 24, rx);
        c0 = sr_cnt;
        host.xfer(sw_w(dev_a, 1'b1, dsb_pkg::CODE_RESET), 24, rx);
        check(sr_cnt - c0, 1);
        check(boost, dsb_pkg::BOOST_RESET);
        check(toggle, 1'b0);
        check(slew, 32'h0);
        // Hardware reset in mid-run after a non-default write
        host.xfer({1'b0, dev_a, 5'h0, dsb_pkg::SEL_BOOST, 6'h0, 7'h7B}, 24, rx);
        check(boost, 7'h7B);
        @(posedge clk_in) reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        check(boost, dsb_pkg::BOOST_RESET);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
